//--- afe_spi_regs.sv
// Serial register port of the sensor front end: instruction decode,
// burst and streaming access, result registers and configuration outputs.
// Assumes the host drives mosi on falling sclk and samples miso on falling sclk.
// Assumes link_sclk keeps running while sys_rst is high so the bank takes its defaults.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module afe_spi_regs #(
  parameter int SAMPLE_WIDTH = 24,
  parameter int NUM_REGS = 128
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic link_sclk,
  input wire logic chip_select_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic signed [SAMPLE_WIDTH-1:0] sample_raw,
  input wire logic sample_valid,
  output logic [6:0] buffer_bypass,
  output logic [2:0] background_cal_mode,
  output logic background_cal_mode_two,
  output logic use_internal_clock
);

  generate
    if (NUM_REGS < 64 || NUM_REGS > 256) begin : g_bad_regs
      $error("afe_spi_regs: NUM_REGS must be 64 to 256");
    end
    if (SAMPLE_WIDTH < 16) begin : g_bad_width
      $error("afe_spi_regs: SAMPLE_WIDTH below 16");
    end
    if (afe_spi_pkg::URA_W + afe_spi_pkg::LRA_W != 8) begin : g_bad_split
      $error("afe_spi_regs: upper and lower address must fill one byte");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // State types

  typedef struct packed {
    afe_spi_pkg::link_phase_t phase;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic rd;
    logic stream;
    logic [1:0] left;
    logic [7:0] addr;
    logic [7:0] start;
    logic setup_done;
    logic miso;
    logic miso_oe;
  } frame_t;

  typedef struct packed {
    logic [afe_spi_pkg::URA_W-1:0] upper_register_address;
    logic [NUM_REGS-1:0][7:0] regs;
  } bank_t;

  typedef struct packed {
    logic [15:0] pending;
    logic [15:0] hold;
    logic [6:0] buffer_bypass;
    logic [2:0] bgcal_mode;
    logic bgcal_two;
    logic int_clk;
  } core_t;

  // Frame state as chip select leaves it; also the asynchronous clear value
  localparam frame_t FRAME_IDLE = '{
    phase: afe_spi_pkg::PH_INSTR, bit_cnt: 3'h0, rx_sh: 8'h00,
    tx_sh: 8'h00, rd: 1'b0, stream: 1'b0, left: 2'h0, addr: 8'h00,
    start: 8'h00, setup_done: 1'b0, miso: 1'b0, miso_oe: 1'b0};

  frame_t frame_ff, nxt_frame;
  bank_t bank_ff, nxt_bank;
  core_t core_ff, nxt_core;

  logic link_rst;
  logic cs_idle_core;
  logic [15:0] clamped;
  afe_spi_pkg::cfg_t cfg_link;
  afe_spi_pkg::cfg_t cfg_core;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [7:0] chan_cfg_addr(input int ch);
    return 8'(afe_spi_pkg::ADDR_CHANNEL0_CONFIG + 8'(2 * ch));
  endfunction : chan_cfg_addr

  // Full register address from the kept upper part and the instruction's lower part
  function automatic logic [7:0] full_addr(
    input logic [afe_spi_pkg::URA_W-1:0] upper_register_address,
    input logic [7:0] instr
  );
    return {upper_register_address, instr[afe_spi_pkg::LRA_W-1:0]};
  endfunction : full_addr

  // Result registers are read only and addresses past the bank are dropped
  function automatic logic reg_writable(input logic [7:0] a);
    return 32'(a) < NUM_REGS
      && a != afe_spi_pkg::ADDR_RESULT_HI
      && a != afe_spi_pkg::ADDR_RESULT_LO;
  endfunction : reg_writable

  // Register read mux; result bytes come from the core hold register
  function automatic logic [7:0] read_byte(
    input logic [7:0] a,
    input bank_t b,
    input logic [15:0] hold
  );
    logic [7:0] v;
    v = 8'h00;
    if (a == afe_spi_pkg::ADDR_RESULT_HI) v = hold[15:8];
    else if (a == afe_spi_pkg::ADDR_RESULT_LO) v = hold[7:0];
    else if (32'(a) < NUM_REGS) v = b.regs[a];
    return v;
  endfunction : read_byte

  // Next address of a burst or stream
  function automatic logic [7:0] next_addr(
    input logic [7:0] a,
    input logic [7:0] start,
    input logic stream,
    input logic [7:0] ctl
  );
    logic [7:0] last;
    last = 8'(start + {5'h0, ctl[afe_spi_pkg::STREAM_LEN_HI:0]});
    if (stream && ctl[afe_spi_pkg::STREAM_TYPE_BIT] && a == last)
      return start;
    return 8'(a + 8'h01);
  endfunction : next_addr

  ////////////////////////////////////////////////////////////////////////////
  // Crossings

  // Reset reaches the link domain through two sclk flops
  level_sync #(.WIDTH(1)) u_rst_sync (
    .clk(link_sclk),
    .d(sys_rst),
    .q(link_rst)
  );

  // Frame select as the core sees it; gates the result hold update
  level_sync #(.WIDTH(1)) u_cs_sync (
    .clk(clk),
    .d(chip_select_n),
    .q(cs_idle_core)
  );

  // Configuration bits only change on a host write or a link reset, so a
  // per-bit level crossing is enough
  always_comb begin
    for (int ch = 0; ch < afe_spi_pkg::NUM_CHANNELS; ch++) begin
      cfg_link.buffer_bypass[ch] = bank_ff.regs[chan_cfg_addr(ch)][afe_spi_pkg::BUF_BYPASS_BIT];
    end
    cfg_link.bgcal_mode = bank_ff.regs[afe_spi_pkg::ADDR_BGCAL][afe_spi_pkg::BGCAL_HI:0];
    cfg_link.clk_det = bank_ff.regs[afe_spi_pkg::ADDR_AUX_CTL][afe_spi_pkg::CLK_DET_BIT];
    cfg_link.clk_sel = bank_ff.regs[afe_spi_pkg::ADDR_AUX_CTL][afe_spi_pkg::CLK_SEL_BIT];
  end

  level_sync #(.WIDTH($bits(afe_spi_pkg::cfg_t))) u_cfg_sync (
    .clk(clk),
    .d(cfg_link),
    .q(cfg_core)
  );

  result_clamp #(.IN_WIDTH(SAMPLE_WIDTH)) u_clamp (
    .raw(sample_raw),
    .code(clamped)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Core domain

  always_comb begin
    nxt_core = core_ff;
    // A sample that lands mid-frame waits in pending until the frame ends
    if (sample_valid) nxt_core.pending = clamped;
    // The hold word is read from the link domain, so it only moves while
    // no frame is open; this keeps it stable for the whole frame
    if (cs_idle_core) nxt_core.hold = core_ff.pending;
    nxt_core.buffer_bypass = cfg_core.buffer_bypass;
    nxt_core.bgcal_mode = cfg_core.bgcal_mode;
    nxt_core.bgcal_two = (cfg_core.bgcal_mode == afe_spi_pkg::BGCAL_MODE_TWO);
    nxt_core.int_clk = cfg_core.clk_det & ~cfg_core.clk_sel;
    if (sys_rst) begin
      nxt_core = '0;
    end
  end

  always_ff @(posedge clk) begin
    core_ff <= nxt_core;
  end

  assign buffer_bypass = core_ff.buffer_bypass;
  assign background_cal_mode = core_ff.bgcal_mode;
  assign background_cal_mode_two = core_ff.bgcal_two;
  assign use_internal_clock = core_ff.int_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: frame engine

  logic [7:0] rx_byte;
  logic byte_done;
  logic [7:0] ld_byte;
  logic [7:0] adv_addr;
  logic wr_en;
  logic [7:0] inst_addr;
  logic setup_wr;
  logic setup_rd;
  logic ura_wr;

  always_comb begin
    rx_byte = {frame_ff.rx_sh[6:0], mosi};
    byte_done = (frame_ff.bit_cnt == 3'h7);
    adv_addr = next_addr(frame_ff.addr, frame_ff.start, frame_ff.stream,
                         bank_ff.regs[afe_spi_pkg::ADDR_STREAM_CTL]);
    ld_byte = 8'h00;
    inst_addr = full_addr(bank_ff.upper_register_address, rx_byte);
    // A setup pair is only taken as the first two bytes of a frame, so the
    // instruction after it is a data access even when it equals a setup code
    setup_wr = !frame_ff.setup_done && rx_byte == afe_spi_pkg::INST_URA_WR;
    setup_rd = !frame_ff.setup_done && rx_byte == afe_spi_pkg::INST_URA_RD;
    wr_en = byte_done && frame_ff.phase == afe_spi_pkg::PH_DATA && !frame_ff.rd;
    ura_wr = byte_done && frame_ff.phase == afe_spi_pkg::PH_URA_WR;

    nxt_frame = frame_ff;
    nxt_frame.rx_sh = rx_byte;
    nxt_frame.bit_cnt = 3'(frame_ff.bit_cnt + 3'h1);
    nxt_frame.miso = frame_ff.tx_sh[7];
    nxt_frame.tx_sh = {frame_ff.tx_sh[6:0], 1'b0};

    if (byte_done) begin
      unique case (frame_ff.phase)
        afe_spi_pkg::PH_INSTR: begin
          if (setup_wr) begin
            nxt_frame.phase = afe_spi_pkg::PH_URA_WR;
          end else if (setup_rd) begin
            nxt_frame.phase = afe_spi_pkg::PH_URA_RD;
            ld_byte = {5'h00, bank_ff.upper_register_address};
            nxt_frame.miso_oe = 1'b1;
          end else begin
            nxt_frame.phase = afe_spi_pkg::PH_DATA;
            nxt_frame.rd = rx_byte[afe_spi_pkg::RW_BIT];
            nxt_frame.stream = (rx_byte[afe_spi_pkg::SIZE_HI:afe_spi_pkg::SIZE_LO]
                                == afe_spi_pkg::SIZE_STREAM);
            nxt_frame.left = rx_byte[afe_spi_pkg::SIZE_HI:afe_spi_pkg::SIZE_LO];
            // Upper part of the address comes from the kept value
            nxt_frame.addr = inst_addr;
            nxt_frame.start = inst_addr;
            if (rx_byte[afe_spi_pkg::RW_BIT]) begin
              ld_byte = read_byte(inst_addr, bank_ff, core_ff.hold);
              nxt_frame.miso_oe = 1'b1;
            end
          end
        end
        afe_spi_pkg::PH_URA_WR: begin
          nxt_frame.phase = afe_spi_pkg::PH_INSTR;
          nxt_frame.setup_done = 1'b1;
        end
        afe_spi_pkg::PH_URA_RD: begin
          nxt_frame.phase = afe_spi_pkg::PH_INSTR;
          nxt_frame.setup_done = 1'b1;
          nxt_frame.miso_oe = 1'b0;
        end
        afe_spi_pkg::PH_DATA: begin
          nxt_frame.addr = adv_addr;
          if (!frame_ff.stream) begin
            if (frame_ff.left == 2'h0) nxt_frame.phase = afe_spi_pkg::PH_DONE;
            else nxt_frame.left = 2'(frame_ff.left - 2'h1);
          end
          if (frame_ff.rd && !(frame_ff.left == 2'h0 && !frame_ff.stream)) begin
            ld_byte = read_byte(adv_addr, bank_ff, core_ff.hold);
          end
        end
        afe_spi_pkg::PH_DONE: begin
          // Bytes past a counted burst are ignored; miso sends zeros
        end
        default: begin
          nxt_frame.phase = afe_spi_pkg::PH_DONE;
        end
      endcase
      nxt_frame.miso = ld_byte[7];
      nxt_frame.tx_sh = {ld_byte[6:0], 1'b0};
    end
  end

  // Raising chip select clears the frame at once, which is what ends a
  // stream and its wrap; no sclk edge is needed after the frame
  always_ff @(posedge link_sclk or posedge chip_select_n) begin
    if (chip_select_n) frame_ff <= FRAME_IDLE;
    else frame_ff <= nxt_frame;
  end

  assign miso = frame_ff.miso;
  assign miso_oe = frame_ff.miso_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: register bank

  always_comb begin
    nxt_bank = bank_ff;
    if (ura_wr) begin
      nxt_bank.upper_register_address = rx_byte[afe_spi_pkg::URA_W-1:0];
    end
    if (wr_en && reg_writable(frame_ff.addr)) begin
      nxt_bank.regs[frame_ff.addr] = rx_byte;
    end
    if (link_rst) begin
      nxt_bank.upper_register_address = afe_spi_pkg::RST_URA;
      for (int a = 0; a < NUM_REGS; a++) begin
        nxt_bank.regs[a] = afe_spi_pkg::reg_default(8'(a));
      end
    end
  end

  always_ff @(posedge link_sclk) begin
    bank_ff <= nxt_bank;
  end

endmodule : afe_spi_regs

//--- afe_spi_pkg.sv
// Constants and types shared by the serial register block.
// Assumes an 8-bit register space reached through a 3-bit upper address.
package afe_spi_pkg;

  // Instruction bytes
  localparam logic [7:0] INST_URA_WR = 8'h10;
  localparam logic [7:0] INST_URA_RD = 8'h90;
  localparam int RW_BIT = 7;
  localparam int SIZE_HI = 6;
  localparam int SIZE_LO = 5;
  localparam int LRA_W = 5;
  localparam int URA_W = 3;
  localparam logic [1:0] SIZE_STREAM = 2'h3;

  // Register offsets
  localparam logic [7:0] ADDR_STREAM_CTL = 8'h03;
  localparam logic [7:0] ADDR_DATA_ONLY1 = 8'h09;
  localparam logic [7:0] ADDR_DATA_ONLY2 = 8'h0A;
  localparam logic [7:0] ADDR_BGCAL = 8'h10;
  localparam logic [7:0] ADDR_DRDY_CTL = 8'h11;
  localparam logic [7:0] ADDR_AUX_CTL = 8'h12;
  localparam logic [7:0] ADDR_CRC_CTL = 8'h13;
  localparam logic [7:0] ADDR_RESULT_HI = 8'h1A;
  localparam logic [7:0] ADDR_RESULT_LO = 8'h1B;
  localparam logic [7:0] ADDR_CH_SCAN = 8'h1F;
  localparam logic [7:0] ADDR_CH0_INPUT = 8'h20;
  localparam logic [7:0] ADDR_CHANNEL0_CONFIG = 8'h21;
  localparam logic [7:0] ADDR_CH_LAST = 8'h2D;
  localparam int NUM_CHANNELS = 7;

  // Field positions
  localparam int STREAM_TYPE_BIT = 7;
  localparam int STREAM_LEN_HI = 2;
  localparam int BUF_BYPASS_BIT = 7;
  localparam int BGCAL_HI = 2;
  localparam int CLK_DET_BIT = 4;
  localparam int CLK_SEL_BIT = 5;
  localparam logic [2:0] BGCAL_MODE_TWO = 3'h2;

  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DATA_ONLY1 = 8'h1A;
  localparam logic [7:0] RST_DATA_ONLY2 = 8'h02;
  localparam logic [7:0] RST_DRDY_CTL = 8'h03;
  localparam logic [7:0] RST_CRC_CTL = 8'h02;
  localparam logic [7:0] RST_CH_SCAN = 8'h30;
  localparam logic [7:0] RST_CH_CONFIG = 8'h70;
  localparam logic [7:0] RST_CH_INPUT0 = 8'h01;
  localparam logic [7:0] RST_CH_INPUT1 = 8'h13;
  localparam logic [7:0] RST_CH_INPUT2 = 8'h25;
  localparam logic [7:0] RST_CH_INPUT3 = 8'h37;
  localparam logic [URA_W-1:0] RST_URA = 3'h0;

  // Result codes
  localparam logic [15:0] CODE_MAX = 16'h7FFF;
  localparam logic [15:0] CODE_MIN = 16'h8000;

  typedef enum logic [2:0] {
    PH_INSTR, PH_URA_WR, PH_URA_RD, PH_DATA, PH_DONE
  } link_phase_t;

  typedef struct packed {
    logic [6:0] buffer_bypass;
    logic [2:0] bgcal_mode;
    logic clk_det;
    logic clk_sel;
  } cfg_t;

  function automatic logic [7:0] reg_default(input logic [7:0] addr);
    logic [7:0] v;
    v = RST_ZERO;
    if (addr == ADDR_DATA_ONLY1) v = RST_DATA_ONLY1;
    if (addr == ADDR_DATA_ONLY2) v = RST_DATA_ONLY2;
    if (addr == ADDR_DRDY_CTL) v = RST_DRDY_CTL;
    if (addr == ADDR_CRC_CTL) v = RST_CRC_CTL;
    if (addr == ADDR_CH_SCAN) v = RST_CH_SCAN;
    if (addr >= ADDR_CH0_INPUT && addr <= ADDR_CH_LAST) begin
      if (addr[0]) v = RST_CH_CONFIG;
      else begin
        unique case (addr[2:1])
          2'h0: v = RST_CH_INPUT0;
          2'h1: v = RST_CH_INPUT1;
          2'h2: v = RST_CH_INPUT2;
          2'h3: v = RST_CH_INPUT3;
        endcase
      end
    end
    return v;
  endfunction : reg_default

endpackage : afe_spi_pkg

//--- level_sync.sv
// Two-flop synchroniser for quasi-static levels.
// Assumes each bit of d changes rarely compared with clk.
`timescale 1ns/100ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge clk) begin
    meta_ff <= d;
    q <= meta_ff;
  end

endmodule : level_sync

//--- result_clamp.sv
// Clamps a wide signed sample into the 16-bit result code.
// Assumes IN_WIDTH of at least 16; purely combinational.
`timescale 1ns/100ps
module result_clamp #(
  parameter int IN_WIDTH = 24
) (
  input wire logic signed [IN_WIDTH-1:0] raw,
  output logic [15:0] code
);

  localparam logic signed [IN_WIDTH-1:0] HI = IN_WIDTH'(signed'(afe_spi_pkg::CODE_MAX));
  localparam logic signed [IN_WIDTH-1:0] LO = IN_WIDTH'(signed'(afe_spi_pkg::CODE_MIN));

  generate
    if (IN_WIDTH < 16) begin : g_bad
      $error("result_clamp: IN_WIDTH below 16");
    end
  endgenerate

  // Saturate rather than wrap on over range
  always_comb begin
    if (raw > HI) code = afe_spi_pkg::CODE_MAX;
    else if (raw < LO) code = afe_spi_pkg::CODE_MIN;
    else code = raw[15:0];
  end

endmodule : result_clamp

//--- afe_spi_regs_properties.sv
// Concurrent checks on the ports of the serial register block.
// Assumes it is bound to afe_spi_regs and sees only that module's ports.
`timescale 1ns/100ps
module afe_spi_regs_properties #(
  parameter int SAMPLE_WIDTH = 24,
  parameter int NUM_REGS = 128
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic link_sclk,
  input wire logic chip_select_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic signed [SAMPLE_WIDTH-1:0] sample_raw,
  input wire logic sample_valid,
  input wire logic [6:0] buffer_bypass,
  input wire logic [2:0] background_cal_mode,
  input wire logic background_cal_mode_two,
  input wire logic use_internal_clock
);
  logic [5:0] idle_ff;
  logic [5:0] edge_ff;

  // Core cycles since the frame select was last low; saturates so it never wraps
  always_ff @(posedge clk) begin
    if (sys_rst) idle_ff <= 6'h3F;
    else if (!chip_select_n) idle_ff <= 6'h00;
    else if (idle_ff != 6'h3F) idle_ff <= idle_ff + 6'h01;
  end

  // Rising sclk edges in the current frame; cleared by select alone since sclk stops between frames
  always_ff @(posedge link_sclk or posedge chip_select_n) begin
    if (chip_select_n) edge_ff <= 6'h00;
    else if (edge_ff != 6'h3F) edge_ff <= edge_ff + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_reset_zero: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(sys_rst) |-> buffer_bypass == 7'h00 && background_cal_mode == 3'h0 && !use_internal_clock
      && !background_cal_mode_two) else $error("config outputs not cleared by reset");
  a_mode_two_set: assert property (@(posedge clk) disable iff (sys_rst)
    (background_cal_mode == 3'h2) [*2] |-> background_cal_mode_two) else $error("mode two flag missing");
  a_mode_two_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (background_cal_mode != 3'h2) [*2] |-> !background_cal_mode_two) else $error("mode two flag stray");
  a_cfg_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    !$stable({buffer_bypass, background_cal_mode, use_internal_clock}) |-> idle_ff < 6'h10)
    else $error("config output moved with no frame");
  a_oe_idle: assert property (@(posedge link_sclk) disable iff (sys_rst)
    chip_select_n |-> !miso_oe) else $error("miso driven while deselected");
  a_oe_drop: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(chip_select_n) |-> ##[0:1] !miso_oe) else $error("miso kept after frame end");
  a_oe_after_instr: assert property (@(posedge link_sclk) disable iff (sys_rst)
    $rose(miso_oe) |-> edge_ff >= 6'h08) else $error("miso driven before instruction end");
  a_oe_early_low: assert property (@(posedge link_sclk) disable iff (sys_rst)
    !chip_select_n && edge_ff < 6'h07 |=> !miso_oe) else $error("miso driven inside first byte");

  c_long_read: cover property (@(posedge link_sclk) miso_oe && edge_ff == 6'h28);
  c_mode_two: cover property (@(posedge clk) $rose(background_cal_mode_two));
  c_int_clock: cover property (@(posedge clk) $rose(use_internal_clock));
endmodule : afe_spi_regs_properties

//--- spi_host_model.sv
// Host end of the serial link: frames built bit by bit, MSB first.
// Assumes the device samples mosi and moves miso on rising sclk; sclk stands low between frames.
`timescale 1ns/100ps
module spi_host_model (
  output logic link_sclk,
  output logic chip_select_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    link_sclk = 1'b0;
    chip_select_n = 1'b1;
    mosi = 1'b0;
  end

  // Clocks with the device deselected, only so its link-side reset can settle
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #3 link_sclk = 1'b1;
      #3 link_sclk = 1'b0;
    end
  endtask : idle_clocks

  // Lead-in lets the core freeze the result before the first edge
  task automatic frame_open();
    chip_select_n = 1'b0;
    #150;
  endtask : frame_open

  // miso is taken while sclk is low, i.e. what the last rising edge put out
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      rx[i] = miso;
      #3 link_sclk = 1'b1;
      #3 link_sclk = 1'b0;
    end
  endtask : xfer

  task automatic frame_close();
    #3 chip_select_n = 1'b1;
    mosi = ~mosi;
    #20;
  endtask : frame_close
endmodule : spi_host_model

//--- tb_top.sv
// Self-checking bench: host model drives frames, expectations come from the register map.
// Assumes the checker module is compiled first and bound at the foot of this file.
`timescale 1ns/100ps
module tb_top;
  logic clk;
  logic sys_rst;
  logic link_sclk;
  logic chip_select_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;
  logic signed [23:0] sample_raw;
  logic sample_valid;
  logic [6:0] buffer_bypass;
  logic [2:0] background_cal_mode;
  logic background_cal_mode_two;
  logic use_internal_clock;
  logic [7:0] rx_q[$];
  logic [23:0] smp[7] = '{24'h7FFFFF, 24'h800000, 24'h008000, 24'hFF7FFF, 24'h007FFF, 24'hFF8000, 24'hFFFFFB};
  logic [15:0] code[7] = '{16'h7FFF, 16'h8000, 16'h7FFF, 16'h8000, 16'h7FFF, 16'h8000, 16'hFFFB};
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;

  afe_spi_regs #(.SAMPLE_WIDTH(24), .NUM_REGS(128)) dut (
    .clk(clk), .sys_rst(sys_rst), .link_sclk(link_sclk), .chip_select_n(chip_select_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .sample_raw(sample_raw), .sample_valid(sample_valid),
    .buffer_bypass(buffer_bypass), .background_cal_mode(background_cal_mode),
    .background_cal_mode_two(background_cal_mode_two), .use_internal_clock(use_internal_clock)
  );
  // A released data line must not read back as a stale bit
  assign miso_line = miso_oe ? miso : ~mosi;
  spi_host_model host (.link_sclk(link_sclk), .chip_select_n(chip_select_n), .mosi(mosi), .miso(miso_line));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : check

  // One whole frame; each byte shifted back lands in rx_q
  task automatic frame(input logic [7:0] tx[$]);
    logic [7:0] b;
    rx_q = {};
    host.frame_open();
    foreach (tx[i]) begin
      host.xfer(tx[i], b);
      rx_q.push_back(b);
    end
    host.frame_close();
    repeat (8) @(posedge clk);
  endtask : frame

  task automatic expect_rx(input int first, input logic [7:0] exp[$]);
    foreach (exp[i]) begin
      check(rx_q[first + i], exp[i]);
    end
  endtask : expect_rx

  task automatic put_sample(input logic [23:0] v);
    @(posedge clk);
    sample_raw <= v;
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : put_sample

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    sample_raw = 24'h000000;
    sample_valid = 1'b0;
    fork
      host.idle_clocks(8);
      repeat (8) @(posedge clk);
    join
    sys_rst <= 1'b0;
    host.idle_clocks(4);
    repeat (4) @(posedge clk);
    frame('{8'h83, 8'h00});
    check(rx_q[1], 8'h00);
    frame('{8'h10, 8'h01});
    frame('{8'h90, 8'h00});
    check(rx_q[1], 8'h01);
    // No setup this time: upper address 1 must still be in force
    frame('{8'h80, 8'h00});
    check(rx_q[1], 8'h01);
    frame('{8'h10, 8'h00, 8'h5F, 8'h31, 8'h02, 8'h80});
    frame('{8'hDF, 8'h00, 8'h00, 8'h00, 8'h00});
    expect_rx(1, '{8'h31, 8'h02, 8'h80, 8'h00});
    check({1'b0, buffer_bypass}, 8'h01);
    frame('{8'h10, 8'h01, 8'hA4, 8'h00, 8'h00});
    expect_rx(3, '{8'h25, 8'h70});
    frame('{8'h68, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46});
    frame('{8'hE8, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    expect_rx(1, '{8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h00});
    // Instruction equal to the setup code only works behind a setup pair
    frame('{8'h10, 8'h00, 8'h10, 8'h02});
    check({5'h00, background_cal_mode}, 8'h02);
    check({7'h00, background_cal_mode_two}, 8'h01);
    frame('{8'h12, 8'h10});
    check({7'h00, use_internal_clock}, 8'h01);
    frame('{8'h12, 8'h30});
    check({7'h00, use_internal_clock}, 8'h00);
    frame('{8'h10, 8'h04, 8'h00, 8'h77});
    frame('{8'h80, 8'h00});
    check(rx_q[1], 8'h00);
    // The dropped write to 0x80 must not alias onto 0x00
    frame('{8'h10, 8'h00, 8'h80, 8'h00});
    check(rx_q[3], 8'h00);
    frame('{8'h10, 8'h00, 8'h03, 8'h81});
    for (int k = 0; k < 7; k++) begin
      put_sample(smp[k]);
      frame('{8'h1A, 8'h55});
      frame('{8'hFA, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
      expect_rx(1, '{code[k][15:8], code[k][7:0], code[k][15:8], code[k][7:0], code[k][15:8]});
    end
    stop_test();
  end
endmodule : tb_top

bind afe_spi_regs afe_spi_regs_properties #(.SAMPLE_WIDTH(SAMPLE_WIDTH), .NUM_REGS(NUM_REGS)) props (
  .clk(clk), .sys_rst(sys_rst), .link_sclk(link_sclk), .chip_select_n(chip_select_n), .mosi(mosi),
  .miso(miso), .miso_oe(miso_oe), .sample_raw(sample_raw), .sample_valid(sample_valid),
  .buffer_bypass(buffer_bypass), .background_cal_mode(background_cal_mode),
  .background_cal_mode_two(background_cal_mode_two), .use_internal_clock(use_internal_clock)
);
